// *** hw/xb_ctrl.sv ***
// External bus, strobe and pin control of a small 8-bit controller.
// Assumes a classic Wishbone master on clk_i; pins come from outside.
// What this block does
// R1 - Software reads or writes the data bus, pulsing read or write strobe.
// R2 - Data bus can be driven statically from a latch without strobes.
// R3 - Fetch drives low 8 address bits, then takes the byte under program strobe.
// R4 - Fetch shows the four high address bits on the port 2 nibble.
// R5 - Port 2 nibble doubles as expander bus, each transfer marked by its strobe.
// R6 - External data store puts address then data out, with latch and strobes.
// R7 - Read strobe pulses low on every bus read and external data read.
// R8 - Write strobe pulses low on every bus write and external data write.
// R9 - Exactly one address-latch pulse in every machine cycle.
// R10 - External memories latch address on the falling address-latch edge.
// R11 - Program strobe is active only on external program fetches.
// R12 - External-access input high sends every fetch to external memory.
// R13 - Single-step input with address latch lets logic step the core.
// R14 - Test input 0 is readable and can become a clock output.
// R15 - Test input 1 is readable and can feed the event counter.
// R16 - Low interrupt input requests only while enabled; level is readable.
// R17 - External interrupt is disabled after every reset.
// R18 - An interrupt source holds the input low three machine cycles.
// R19 - Low reset input initialises the block.
// R20 - Bus work is scheduled in whole machine cycles.
// R21 - Data bus is released while read or program strobe is active.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module xb_ctrl
  import xb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Data bus
  input wire logic [7:0] data_bus_lines_i,
  output logic [7:0] data_bus_lines_o,
  output logic data_bus_lines_oe_o,
  // Port 2 low nibble
  input wire logic [3:0] port2_low_nibble_i,
  output logic [3:0] port2_low_nibble_o,
  output logic port2_low_nibble_oe_o,
  // Strobes
  output logic ale_o,
  output logic program_store_strobe_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic expander_strobe_n_o,
  // Control pins
  input wire logic external_access_in_i,
  input wire logic single_step_n_i,
  input wire logic test_input_zero_i,
  output logic test_input_zero_o,
  output logic test_input_zero_oe_o,
  input wire logic test_input_one_i,
  input wire logic int_n_i,
  output logic int_request_o
);
  import xb_pkg::*;

  typedef struct packed {
    logic ack;
    logic [3:0] ctrl;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic [7:0] latch;
    logic [7:0] rdata;
    xb_op_t op;
    xb_op_t pend_op;
    logic pend;
    logic [3:0] phase;
    logic halted;
    logic int_fetch;
    logic [7:0] count;
    logic [1:0] clkdiv;
    logic [7:0] db_s1;
    logic [7:0] db_s2;
    logic [3:0] p2_s1;
    logic [3:0] p2_s2;
    logic tin0_s1;
    logic tin0_s2;
    logic tin1_s1;
    logic tin1_s2;
    logic tin1_d;
    logic int_s1;
    logic int_s2;
    logic xacc_s1;
    logic xacc_s2;
    logic ss_s1;
    logic ss_s2;
  } xb_state_t;

  xb_state_t st_reg;
  xb_state_t st_next;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic busy;
  logic in_addr;
  logic in_stb;
  xb_op_t cmd_op;
  logic cmd_ok;

  // ==================== Bus decode ====================
  always_comb
  begin
    wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wval = wb_dat_i & wmask;
    busy = st_reg.pend | (st_reg.op != XB_OP_NONE);
    in_addr = st_reg.phase < XB_ADR_END;
    in_stb = (st_reg.phase >= XB_STB_ON) & (st_reg.phase < XB_STB_OFF);
    cmd_ok = 1'b1;
    case (wb_dat_i[2:0])
      XB_CMD_FETCH: cmd_op = XB_OP_FETCH;
      XB_CMD_XRD: cmd_op = XB_OP_XRD;
      XB_CMD_XWR: cmd_op = XB_OP_XWR;
      XB_CMD_BRD: cmd_op = XB_OP_BRD;
      XB_CMD_BWR: cmd_op = XB_OP_BWR;
      XB_CMD_EXRD: cmd_op = XB_OP_EXRD;
      XB_CMD_EXWR: cmd_op = XB_OP_EXWR;
      default:
      begin
        cmd_op = XB_OP_NONE;
        cmd_ok = 1'b0;
      end
    endcase
  end

  // ==================== Next state ====================
  always_comb
  begin
    st_next = st_reg;
    // Pin synchronisers
    st_next.db_s1 = data_bus_lines_i;
    st_next.db_s2 = st_reg.db_s1;
    st_next.p2_s1 = port2_low_nibble_i;
    st_next.p2_s2 = st_reg.p2_s1;
    st_next.tin0_s1 = test_input_zero_i;
    st_next.tin0_s2 = st_reg.tin0_s1;
    st_next.tin1_s1 = test_input_one_i;
    st_next.tin1_s2 = st_reg.tin1_s1;
    st_next.tin1_d = st_reg.tin1_s2;
    st_next.int_s1 = int_n_i;
    st_next.int_s2 = st_reg.int_s1;
    st_next.xacc_s1 = external_access_in_i;
    st_next.xacc_s2 = st_reg.xacc_s1;
    st_next.ss_s1 = single_step_n_i;
    st_next.ss_s2 = st_reg.ss_s1;

    st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;

    // Test 0 clock output divider
    if (st_reg.clkdiv == XB_CLK_DIV_LAST)
      st_next.clkdiv = 2'h0;
    else
      st_next.clkdiv = st_reg.clkdiv + 2'h1;

    // Event counter on falling test 1 edges
    if (st_reg.ctrl[XB_CTRL_EV_CNT] & st_reg.tin1_d & ~st_reg.tin1_s2)
      st_next.count = st_reg.count + 8'h01; // R15

    // Machine cycle sequencer, halted at ALE while stepping
    if (st_reg.halted)
    begin
      if (st_reg.ss_s2)
        st_next.halted = 1'b0; // R13
    end
    else if (st_reg.phase == XB_MC_LAST)
    begin
      st_next.phase = 4'h0; // R20
      st_next.halted = ~st_reg.ss_s2; // R13
      st_next.op = XB_OP_NONE;
      if (st_reg.pend)
      begin
        st_next.pend = 1'b0;
        st_next.op = st_reg.pend_op;
        if (st_reg.pend_op == XB_OP_FETCH)
        begin
          st_next.int_fetch = ~st_reg.xacc_s2;
          if (~st_reg.xacc_s2)
            st_next.op = XB_OP_IFETCH; // R12
        end
        if (st_reg.pend_op == XB_OP_BWR)
          st_next.latch = st_reg.wdata; // R2
      end
    end
    else
      st_next.phase = st_reg.phase + 4'h1;

    // Returned data capture
    case (st_reg.op)
      XB_OP_FETCH:
        if (st_reg.phase == XB_SMP_FETCH)
          st_next.rdata = st_reg.db_s2; // R3
      XB_OP_XRD, XB_OP_BRD:
        if (st_reg.phase == XB_SMP_RD)
          st_next.rdata = st_reg.db_s2; // R1
      XB_OP_EXRD:
        if (st_reg.phase == XB_SMP_RD)
          st_next.rdata = {4'h0, st_reg.p2_s2}; // R5
      default:
        st_next.rdata = st_reg.rdata;
    endcase

    // Register writes, taken at the acknowledging edge
    if (wr_hit)
    begin
      case (wb_adr_i)
        XB_CTRL_OFS:
          st_next.ctrl = (st_reg.ctrl & ~wmask[3:0]) | wval[3:0];
        XB_ADDR_OFS:
          st_next.addr = (st_reg.addr & ~wmask[11:0]) | wval[11:0];
        XB_WDATA_OFS:
          st_next.wdata = (st_reg.wdata & ~wmask[7:0]) | wval[7:0];
        XB_COUNT_OFS:
          st_next.count = (st_reg.count & ~wmask[7:0]) | wval[7:0];
        XB_CMD_OFS:
          if (wb_sel_i[0] & cmd_ok & ~busy)
          begin
            st_next.pend = 1'b1;
            st_next.pend_op = cmd_op;
          end
        default:
          st_next.ctrl = st_reg.ctrl;
      endcase
    end
  end

  // ==================== State register ====================
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= '0; // R19
      st_reg.ctrl <= XB_CTRL_RST; // R17
      st_reg.op <= XB_OP_NONE;
      st_reg.pend_op <= XB_OP_NONE;
      st_reg.db_s1 <= 8'hFF;
      st_reg.db_s2 <= 8'hFF;
      st_reg.int_s1 <= 1'b1;
      st_reg.int_s2 <= 1'b1;
      st_reg.ss_s1 <= 1'b1;
      st_reg.ss_s2 <= 1'b1;
    end
    else if (ce_i)
      st_reg <= st_next;
  end

  // ==================== Register read ====================
  always_comb
  begin
    wb_dat_o = 32'h0000_0000;
    wb_ack_o = st_reg.ack;
    case (wb_adr_i)
      XB_CTRL_OFS: wb_dat_o[3:0] = st_reg.ctrl;
      XB_ADDR_OFS: wb_dat_o[11:0] = st_reg.addr;
      XB_WDATA_OFS: wb_dat_o[7:0] = st_reg.wdata;
      XB_STAT_OFS:
        wb_dat_o[7:0] = {st_reg.int_fetch, st_reg.halted, st_reg.xacc_s2, int_request_o,
                         st_reg.int_s2, st_reg.tin1_s2, st_reg.tin0_s2, busy}; // R14
      XB_RDATA_OFS: wb_dat_o[7:0] = st_reg.rdata;
      XB_COUNT_OFS: wb_dat_o[7:0] = st_reg.count;
      default: wb_dat_o = 32'h0000_0000;
    endcase
  end

  // ==================== Pin drive ====================
  always_comb
  begin
    ale_o = (st_reg.phase < XB_ALE_END) | st_reg.halted; // R9
    program_store_strobe_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    expander_strobe_n_o = 1'b1;
    data_bus_lines_o = st_reg.latch;
    data_bus_lines_oe_o = st_reg.ctrl[XB_CTRL_STATIC]; // R2
    port2_low_nibble_o = 4'h0;
    port2_low_nibble_oe_o = 1'b0;
    case (st_reg.op)
      XB_OP_FETCH:
      begin
        port2_low_nibble_o = st_reg.addr[11:8]; // R4
        port2_low_nibble_oe_o = 1'b1;
        data_bus_lines_o = st_reg.addr[7:0]; // R3
        data_bus_lines_oe_o = in_addr; // R21
        program_store_strobe_n_o = ~((st_reg.phase >= XB_STB_ON) & (st_reg.phase < XB_PSTB_OFF)); // R11
      end
      XB_OP_XRD:
      begin
        data_bus_lines_o = st_reg.addr[7:0];
        data_bus_lines_oe_o = in_addr; // R21
        rd_n_o = ~in_stb; // R7
      end
      XB_OP_XWR:
      begin
        data_bus_lines_o = in_addr ? st_reg.addr[7:0] : st_reg.wdata; // R6
        data_bus_lines_oe_o = 1'b1;
        wr_n_o = ~in_stb; // R8
      end
      XB_OP_BRD:
      begin
        data_bus_lines_oe_o = 1'b0;
        rd_n_o = ~in_stb; // R1
      end
      XB_OP_BWR:
      begin
        data_bus_lines_o = st_reg.wdata;
        data_bus_lines_oe_o = 1'b1;
        wr_n_o = ~in_stb; // R1
      end
      XB_OP_EXRD, XB_OP_EXWR:
      begin
        expander_strobe_n_o = ~in_stb; // R5
        port2_low_nibble_oe_o = (st_reg.phase < XB_STB_ON) | (st_reg.op == XB_OP_EXWR);
        port2_low_nibble_o = (st_reg.phase < XB_STB_ON) ? st_reg.addr[3:0] : st_reg.wdata[3:0];
      end
      default:
        data_bus_lines_o = st_reg.latch;
    endcase
    test_input_zero_o = (st_reg.clkdiv == 2'h0);
    test_input_zero_oe_o = st_reg.ctrl[XB_CTRL_CLK_OUT]; // R14
    int_request_o = st_reg.ctrl[XB_CTRL_INT_EN] & ~st_reg.int_s2; // R16
  end

endmodule

// *** hw/xb_pkg.sv ***
// Constants, op codes and register map of the external bus controller.
// Assumes a 32-bit classic Wishbone register port on a single clock.
package xb_pkg;

  // ==================== Register map ====================
  localparam logic [7:0] XB_CTRL_OFS = 8'h00;
  localparam logic [7:0] XB_ADDR_OFS = 8'h04;
  localparam logic [7:0] XB_WDATA_OFS = 8'h08;
  localparam logic [7:0] XB_CMD_OFS = 8'h0C;
  localparam logic [7:0] XB_STAT_OFS = 8'h10;
  localparam logic [7:0] XB_RDATA_OFS = 8'h14;
  localparam logic [7:0] XB_COUNT_OFS = 8'h18;

  // ==================== Control fields ====================
  localparam int XB_CTRL_INT_EN = 0;
  localparam int XB_CTRL_CLK_OUT = 1;
  localparam int XB_CTRL_EV_CNT = 2;
  localparam int XB_CTRL_STATIC = 3;
  localparam logic [3:0] XB_CTRL_RST = 4'h0;

  // ==================== Command codes ====================
  localparam logic [2:0] XB_CMD_FETCH = 3'h1;
  localparam logic [2:0] XB_CMD_XRD = 3'h2;
  localparam logic [2:0] XB_CMD_XWR = 3'h3;
  localparam logic [2:0] XB_CMD_BRD = 3'h4;
  localparam logic [2:0] XB_CMD_BWR = 3'h5;
  localparam logic [2:0] XB_CMD_EXRD = 3'h6;
  localparam logic [2:0] XB_CMD_EXWR = 3'h7;

  // ==================== Machine cycle phases ====================
  localparam logic [3:0] XB_MC_LAST = 4'hE;
  localparam logic [3:0] XB_ALE_END = 4'h3;
  localparam logic [3:0] XB_ADR_END = 4'h4;
  localparam logic [3:0] XB_STB_ON = 4'h5;
  localparam logic [3:0] XB_STB_OFF = 4'hD;
  localparam logic [3:0] XB_PSTB_OFF = 4'hC;
  localparam logic [3:0] XB_SMP_FETCH = 4'hB;
  localparam logic [3:0] XB_SMP_RD = 4'hC;
  localparam logic [1:0] XB_CLK_DIV_LAST = 2'h2;

  typedef enum logic [3:0] {
    XB_OP_NONE, XB_OP_FETCH, XB_OP_IFETCH, XB_OP_XRD, XB_OP_XWR,
    XB_OP_BRD, XB_OP_BWR, XB_OP_EXRD, XB_OP_EXWR
  } xb_op_t;

endpackage

// *** test/tb_xb_ctrl.sv ***
// Bench for xb_ctrl: Wishbone commands, pin checks.
// Assumes xb_mem_model on the far side.
`timescale 1ns/10ps
module tb_xb_ctrl;
  import xb_pkg::*;
  // ====================
  // Signals
  logic clk_i = 1'h0, nrst_i = 1'h0, ce_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, data_bus_lines_i, data_bus_lines_o, bm;
  logic [3:0] wb_sel_i = 4'hF, port2_low_nibble_i, port2_low_nibble_o, pm, p2_seen, exp_seen;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd_v;
  logic wb_ack_o, data_bus_lines_oe_o, port2_low_nibble_oe_o, ale_o, program_store_strobe_n_o, rd_n_o;
  logic wr_n_o, expander_strobe_n_o, test_input_zero_i, test_input_zero_o, test_input_zero_oe_o, int_request_o;
  logic external_access_in_i = 1'h1, single_step_n_i = 1'h1, zdrv = 1'h0, test_input_one_i = 1'h1, int_n_i = 1'h1;
  int fail_count = 0, cmp_count = 0, cyc_n = 0, ps_cnt = 0, n0;
  assign data_bus_lines_i = data_bus_lines_oe_o ? data_bus_lines_o : bm;
  assign port2_low_nibble_i = port2_low_nibble_oe_o ? port2_low_nibble_o : pm;
  assign test_input_zero_i = test_input_zero_oe_o ? test_input_zero_o : zdrv;
  xb_ctrl dut (.*);
  xb_mem_model u_mem (.clk_i(clk_i), .ale_i(ale_o), .ps_n_i(program_store_strobe_n_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .ex_n_i(expander_strobe_n_o), .oe_i(data_bus_lines_oe_o),
    .p2_oe_i(port2_low_nibble_oe_o), .bus_i(data_bus_lines_i), .bus_o(bm), .p2_o(pm));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  // Pin monitors and run limit
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (!program_store_strobe_n_o)
    begin
      ps_cnt <= ps_cnt + 1;
      p2_seen <= port2_low_nibble_o;
    end
    if (!expander_strobe_n_o && port2_low_nibble_oe_o)
      exp_seen <= port2_low_nibble_o;
    if (cyc_n == 10000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'h1);
    rd_v = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, '0);
    chk(rd_v, e);
  endtask
  task automatic run(input logic [2:0] c);
    wb(1'h1, XB_CMD_OFS, {29'h0, c});
    do
      wb(1'h0, XB_STAT_OFS, '0);
    while (rd_v[0] !== 1'h0);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ====================
  // Tests
  initial
  begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'h1;
    rc(XB_CTRL_OFS, '0);
    rc(8'h1C, '0);
    wb(1'h1, XB_ADDR_OFS, 32'h0000_0037);
    wb(1'h1, XB_WDATA_OFS, 32'h0000_00C3);
    run(XB_CMD_XWR);
    run(XB_CMD_XRD);
    rc(XB_RDATA_OFS, 32'h0000_00C3);
    run(XB_CMD_BRD);
    rc(XB_RDATA_OFS, 32'h0000_00C3);
    wb(1'h1, XB_WDATA_OFS, 32'h0000_0096);
    run(XB_CMD_BWR);
    wb(1'h1, XB_CTRL_OFS, 32'h0000_0008);
    repeat (20) @(posedge clk_i);
    chk({23'h0, data_bus_lines_oe_o, data_bus_lines_o}, 32'h0000_0196);
    wb(1'h1, XB_CTRL_OFS, '0);
    $display("bus test done");
    wb(1'h1, XB_ADDR_OFS, 32'h0000_0A45);
    run(XB_CMD_FETCH);
    rc(XB_RDATA_OFS, 32'h0000_001F);
    chk({28'h0, p2_seen}, 32'h0000_000A);
    external_access_in_i <= 1'h0;
    n0 = ps_cnt;
    run(XB_CMD_FETCH);
    chk(ps_cnt, n0);
    wb(1'h0, XB_STAT_OFS, '0);
    chkb(rd_v[7], 1'h1);
    external_access_in_i <= 1'h1;
    $display("fetch test done");
    wb(1'h1, XB_ADDR_OFS, 32'h0000_0005);
    wb(1'h1, XB_WDATA_OFS, 32'h0000_0009);
    run(XB_CMD_EXWR);
    chk({28'h0, exp_seen}, 32'h0000_0009);
    run(XB_CMD_EXRD);
    wb(1'h0, XB_RDATA_OFS, '0);
    chk({28'h0, rd_v[3:0]}, 32'h0000_0006);
    $display("expander test done");
    int_n_i <= 1'h0;
    repeat (50) @(posedge clk_i);
    wb(1'h0, XB_STAT_OFS, '0);
    chkb(rd_v[3], 1'h0);
    chkb(int_request_o, 1'h0);
    wb(1'h1, XB_CTRL_OFS, 32'h0000_0001);
    repeat (4) @(posedge clk_i);
    chkb(int_request_o, 1'h1);
    nrst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'h1;
    rc(XB_CTRL_OFS, '0);
    chkb(int_request_o, 1'h0);
    int_n_i <= 1'h1;
    $display("interrupt test done");
    zdrv <= 1'h1;
    test_input_one_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    wb(1'h0, XB_STAT_OFS, '0);
    chk({30'h0, rd_v[2:1]}, 32'h0000_0001);
    wb(1'h1, XB_COUNT_OFS, '0);
    wb(1'h1, XB_CTRL_OFS, 32'h0000_0006);
    repeat (3)
    begin
      test_input_one_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      test_input_one_i <= 1'h0;
      repeat (4) @(posedge clk_i);
    end
    rc(XB_COUNT_OFS, 32'h0000_0003);
    chkb(test_input_zero_oe_o, 1'h1);
    n0 = 0;
    repeat (3)
    begin
      @(posedge clk_i);
      n0 += test_input_zero_i;
    end
    chk(n0, 1);
    single_step_n_i <= 1'h0;
    repeat (40) @(posedge clk_i);
    wb(1'h0, XB_STAT_OFS, '0);
    chkb(rd_v[6], 1'h1);
    chkb(ale_o, 1'h1);
    single_step_n_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    wb(1'h0, XB_STAT_OFS, '0);
    chkb(rd_v[6], 1'h0);
    $display("pin test done");
    end_sim();
  end
endmodule

// *** test/xb_ctrl_props.sv ***
// Pin checker for xb_ctrl.
// Assumes ce_i held high.
`timescale 1ns/10ps
module xb_ctrl_props (
  // Watched pins
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ale_o,
  input wire logic program_store_strobe_n_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic data_bus_lines_oe_o,
  input wire logic int_request_o
);
  // ====================
  // Checks
  wire ps = program_store_strobe_n_o;
  wire oe = data_bus_lines_oe_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence rd_pulse;
    !rd_n_o [*8] ##1 rd_n_o;
  endsequence
  sequence ps_pulse;
    !ps [*7] ##1 ps;
  endsequence
  a_rd_width: assert property ($fell(rd_n_o) |-> rd_pulse) else $error("rd width");
  a_wr_width: assert property ($fell(wr_n_o) |-> !wr_n_o [*8] ##1 wr_n_o) else $error("wr width");
  a_ps_width: assert property ($fell(ps) |-> ps_pulse) else $error("program strobe width");
  a_ale_low: assert property ($fell(ale_o) |-> !ale_o [*8]) else $error("ale low");
  a_ale_high: assert property ($rose(ale_o) |-> ale_o [*3]) else $error("ale high");
  a_rd_float: assert property (!rd_n_o |-> !oe) else $error("bus driven in read");
  a_ps_float: assert property (!ps |-> !oe && !ale_o) else $error("bus driven in fetch");
  a_wr_drive: assert property (!wr_n_o |-> oe && rd_n_o) else $error("write data");
  a_int_reset: assert property (disable iff (1'b0) !nrst_i |=> !int_request_o) else $error("irq reset");
endmodule

bind xb_ctrl xb_ctrl_props u_props (.clk_i(clk_i), .nrst_i(nrst_i), .ale_o(ale_o),
  .program_store_strobe_n_o(program_store_strobe_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
  .data_bus_lines_oe_o(data_bus_lines_oe_o), .int_request_o(int_request_o));

// *** test/xb_mem_model.sv ***
// Far side: address latch, memory, expander.
// Bench resolves the shared pins.
`timescale 1ns/10ps
module xb_mem_model (
  // Pins seen
  input wire logic clk_i,
  input wire logic ale_i,
  input wire logic ps_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ex_n_i,
  input wire logic oe_i,
  input wire logic p2_oe_i,
  input wire logic [7:0] bus_i,
  // Drive
  output logic [7:0] bus_o,
  output logic [3:0] p2_o
);
  // ====================
  // Memory
  logic [7:0] mem [256];
  logic [7:0] lat = 8'h00;
  logic ale_q = 1'h0;
  logic wr_q = 1'h1;
  initial
  begin
    bus_o = 8'h00;
    p2_o = 4'h0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end
  // Released lines toggle
  always @(posedge clk_i)
  begin
    ale_q <= ale_i;
    wr_q <= wr_n_i;
    if (ale_q && !ale_i && oe_i)
      lat <= bus_i;
    if (!wr_q && wr_n_i)
      mem[lat] <= bus_i;
    bus_o <= (!rd_n_i || !ps_n_i) ? mem[lat] : ~bus_o;
    p2_o <= (!ex_n_i && !p2_oe_i) ? 4'h6 : ~p2_o;
  end
endmodule
